// [verilog/bdm_pkg.sv]
package bdm_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int PC_W = 11;
    localparam int PAGE_W = 8;
    localparam int RAM_ADDR_W = 7;
    localparam int RAM_DEPTH = 128;
    localparam int BANK_CNT = 2;

    localparam logic [ADDR_W-1:0] OFF_IND_ZERO = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_PTR_ZERO = 8'h01;
    localparam logic [ADDR_W-1:0] OFF_IND_ONE = 8'h02;
    localparam logic [ADDR_W-1:0] OFF_PTR_ONE = 8'h03;
    localparam logic [ADDR_W-1:0] OFF_BANK_SEL = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_ACCUM = 8'h05;
    localparam logic [ADDR_W-1:0] OFF_PC_LOW = 8'h06;
    localparam logic [ADDR_W-1:0] OFF_NV_CTRL = 8'h40;

    localparam logic [ADDR_W-1:0] SFR_LAST = 8'h4f;
    localparam logic [ADDR_W-1:0] GP_FIRST = 8'h50;
    localparam logic [ADDR_W-1:0] GP_LAST = 8'h7f;
    localparam logic [ADDR_W-1:0] BANK_ONE_SEL = 8'h01;

    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [DATA_W-1:0] BANK_SEL_RESET = 8'h00;
    localparam int BANK_BIT = 0;
    localparam logic [3:0] NV_CTRL_MASK = 4'h0;

    // one data-memory access request from the core
    typedef struct packed {
        logic rd;
        logic wr;
        logic acc;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bdm_req_t;

    // resolved target of an access
    typedef struct packed {
        logic bank;
        logic [RAM_ADDR_W-1:0] addr;
        logic null_hit;
    } bdm_target_t;

    typedef enum logic [1:0] {
        BDM_RUN = 2'b00,
        BDM_DUMMY = 2'b01
    } bdm_state_t;
endpackage : bdm_pkg

// [verilog/bdm_addr_resolve.sv]
`timescale 1ns/1ps
`default_nettype none
module bdm_addr_resolve
    import bdm_pkg::*;
(
    input wire logic [ADDR_W-1:0] directAddr,
    input wire logic [DATA_W-1:0] ptrZero,
    input wire logic [DATA_W-1:0] ptrOne,
    input wire logic bankSelBit,
    output bdm_target_t target
);
    wire logic isIndZero = (directAddr == OFF_IND_ZERO);
    wire logic isIndOne = (directAddr == OFF_IND_ONE);
    wire logic [ADDR_W-1:0] effAddr = isIndZero ? ptrZero : (isIndOne ? ptrOne : directAddr); // RULE5
    // first port bank 0 only, second port follows bank select, direct is bank 0
    wire logic effBank = isIndOne ? bankSelBit : 1'b0; // RULE6 RULE9
    // pointer aimed back at a port gives a null access
    wire logic nullHit = (isIndZero | isIndOne)
        & ((effAddr == OFF_IND_ZERO) | (effAddr == OFF_IND_ONE)); // RULE7

    assign target.bank = effBank;
    assign target.addr = effAddr[RAM_ADDR_W-1:0]; // RULE17
    assign target.null_hit = nullHit;
endmodule : bdm_addr_resolve
`default_nettype wire

// [verilog/bdm_gp_ram.sv]
`timescale 1ns/1ps
`default_nettype none
module bdm_gp_ram
    import bdm_pkg::*;
(
    input wire logic mclk,
    input wire logic wrEn,
    input wire logic bank,
    input wire logic [RAM_ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    output logic [DATA_W-1:0] rdata
);
    // no reset on the array: ram content is undefined after power-up
    logic [DATA_W-1:0] mem [BANK_CNT*RAM_DEPTH];
    wire logic [RAM_ADDR_W:0] idx = {bank, addr};

    always_ff @(posedge mclk) begin
        if (wrEn) begin
            mem[idx] <= wdata; // RULE4
        end
    end
    assign rdata = mem[idx];
endmodule : bdm_gp_ram
`default_nettype wire

// [verilog/bdm_data_memory.sv]
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE1: two data banks exist and bit 0 of the bank select register picks bank 0 or bank 1.
// RULE2: special registers answer in any bank except the nv control register at 40H, seen only in bank 1.
// RULE3: every bank starts at address 00H.
// RULE4: each general purpose location can be read and written.
// RULE5: access to an indirect port goes to the location in its pointer, never to the port.
// RULE6: the first port reaches bank 0 only and the second port the bank that bank select names.
// RULE7: an indirect port reached indirectly reads 00H and ignores writes.
// RULE8: both pointers are real registers that read, write and modify normally.
// RULE9: direct addressing always hits bank 0; bank 1 is reached only through the second pointer.
// RULE10: reset clears the bank select except a watchdog reset during power-down, which keeps it.
// RULE11: bits 7 to 1 of bank select read as zero.
// RULE12: unused special locations read 00H.
// RULE13: register to register moves pass through the accumulator, which also takes alu results.
// RULE14: writing pc low jumps within the current page and keeps the upper counter bits.
// RULE15: a pc low write inserts one dummy cycle before the target runs.
// RULE16: the nv control register is reached only with pointer one at 40H and bank select at 01H.
// RULE17: the second port address is the bank bit joined to the low seven bits of pointer one.
module bdm_data_memory
    import bdm_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic wdtSleepReset,
    input wire bdm_req_t req,
    input wire logic aluResultValid,
    input wire logic [DATA_W-1:0] aluResult,
    input wire logic pcAdvance,
    input wire logic [PC_W-1:0] pcLoadValue,
    input wire logic pcLoad,
    output logic [DATA_W-1:0] readData,
    output logic [DATA_W-1:0] accumOut,
    output logic [PC_W-1:0] pcOut,
    output logic dummyCycle,
    output logic nvCtrlWrite,
    output logic [3:0] nvCtrlData,
    output logic [DATA_W-1:0] bankSelOut
);
    logic [DATA_W-1:0] ptrZero_reg;
    logic [DATA_W-1:0] ptrOne_reg;
    logic bankSel_reg;
    logic keepBank_reg;
    logic [DATA_W-1:0] accum_reg;
    logic [PC_W-1:0] pc_reg;
    logic [3:0] nvCtrl_reg;
    logic [DATA_W-1:0] readData_reg;
    logic nvCtrlWrite_reg;
    bdm_state_t state_reg;
    bdm_state_t state_next;
    bdm_target_t target;
    logic [DATA_W-1:0] ramRdata;

    bdm_addr_resolve uResolve (
        .directAddr(req.addr),
        .ptrZero(ptrZero_reg),
        .ptrOne(ptrOne_reg),
        .bankSelBit(bankSel_reg),
        .target(target)
    );

    wire logic [ADDR_W-1:0] tgtAddr = {1'b0, target.addr};
    wire logic inGp = (tgtAddr >= GP_FIRST) && (tgtAddr <= GP_LAST); // RULE3
    wire logic hitPtrZero = !target.null_hit && tgtAddr == OFF_PTR_ZERO;
    wire logic hitPtrOne = !target.null_hit && tgtAddr == OFF_PTR_ONE;
    wire logic hitBankSel = !target.null_hit && tgtAddr == OFF_BANK_SEL;
    wire logic hitAccum = !target.null_hit && tgtAddr == OFF_ACCUM;
    wire logic hitPcLow = !target.null_hit && tgtAddr == OFF_PC_LOW;
    // nv control only under bank 1 through pointer one
    wire logic hitNv = !target.null_hit && target.bank && tgtAddr == OFF_NV_CTRL
        && bankSelOut == BANK_ONE_SEL && ptrOne_reg == OFF_NV_CTRL; // RULE2 RULE16
    wire logic gpWrite = req.wr && inGp && !target.null_hit; // RULE4
    wire logic stall = (state_reg == BDM_DUMMY);
    wire logic doWr = req.wr && !stall;
    wire logic doRd = req.rd && !stall;

    // special registers except nv control are shared across banks, so bank only splits the gp area and nv control
    bdm_gp_ram uRam (
        .mclk(mclk),
        .wrEn(gpWrite && !stall),
        .bank(target.bank),
        .addr(target.addr),
        .wdata(req.wdata),
        .rdata(ramRdata)
    );

    wire logic [DATA_W-1:0] bankRead = {{(DATA_W-1){1'b0}}, bankSel_reg}; // RULE11
    wire logic [DATA_W-1:0] rdMux =
        target.null_hit ? ZERO_BYTE : // RULE7
        hitPtrZero ? ptrZero_reg :
        hitPtrOne ? ptrOne_reg :
        hitBankSel ? bankRead :
        hitAccum ? accum_reg :
        hitPcLow ? pc_reg[PAGE_W-1:0] :
        hitNv ? {4'h0, nvCtrl_reg} :
        inGp ? ramRdata : ZERO_BYTE; // RULE12

    assign readData = readData_reg;
    assign accumOut = accum_reg;
    assign pcOut = pc_reg;
    assign dummyCycle = stall;
    assign nvCtrlWrite = nvCtrlWrite_reg;
    assign nvCtrlData = nvCtrl_reg;
    assign bankSelOut = bankRead;

    wire logic pcLowWrite = doWr && hitPcLow;
    assign state_next = pcLowWrite ? BDM_DUMMY : BDM_RUN; // RULE15

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= BDM_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ptrZero_reg <= ZERO_BYTE;
            ptrOne_reg <= ZERO_BYTE;
        end else begin
            if (doWr && hitPtrZero) begin
                ptrZero_reg <= req.wdata; // RULE8
            end
            if (doWr && hitPtrOne) begin
                ptrOne_reg <= req.wdata; // RULE8
            end
        end
    end

    // no reset here: an async clear would wipe the watchdog-in-sleep hint the moment reset rises
    always_ff @(posedge mclk) begin
        keepBank_reg <= wdtSleepReset; // RULE10
    end

    // bank select is synchronous-cleared so a watchdog wake can keep it
    always_ff @(posedge mclk) begin
        if (rst && !keepBank_reg) begin
            bankSel_reg <= BANK_SEL_RESET[BANK_BIT]; // RULE10
        end else if (!rst && doWr && hitBankSel) begin
            bankSel_reg <= req.wdata[BANK_BIT]; // RULE1
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            accum_reg <= ZERO_BYTE;
        end else if (doWr && req.acc) begin
            accum_reg <= req.wdata; // RULE13
        end else if (aluResultValid && !stall) begin
            accum_reg <= aluResult; // RULE13
        end else if (doWr && hitAccum) begin
            accum_reg <= req.wdata;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pc_reg <= {PC_W{1'b0}};
        end else if (pcLowWrite) begin
            pc_reg <= {pc_reg[PC_W-1:PAGE_W], req.wdata}; // RULE14
        end else if (pcLoad && !stall) begin
            pc_reg <= pcLoadValue;
        end else if (pcAdvance && !stall) begin
            pc_reg <= pc_reg + 11'h001;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            nvCtrl_reg <= NV_CTRL_MASK;
            nvCtrlWrite_reg <= 1'b0;
        end else begin
            nvCtrlWrite_reg <= doWr && hitNv; // RULE16
            if (doWr && hitNv) begin
                nvCtrl_reg <= req.wdata[3:0];
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            readData_reg <= ZERO_BYTE;
        end else if (doRd) begin
            readData_reg <= rdMux; // RULE5
        end
    end

    chk_pcl_dummy: assert property (@(posedge mclk) disable iff (rst)
        pcLowWrite |=> dummyCycle ##1 !dummyCycle) else $error("no single dummy cycle"); // RULE15
    chk_pcl_page: assert property (@(posedge mclk) disable iff (rst)
        pcLowWrite |=> pcOut[PC_W-1:PAGE_W] == $past(pc_reg[PC_W-1:PAGE_W])
        && pcOut[PAGE_W-1:0] == $past(req.wdata)) else $error("pc low jump left page"); // RULE14
    chk_bank_upper: assert property (@(posedge mclk) disable iff (rst)
        bankSelOut[DATA_W-1:1] == 7'h00) else $error("bank select upper bits set"); // RULE11
    chk_null_read: assert property (@(posedge mclk) disable iff (rst)
        doRd && target.null_hit |=> readData == ZERO_BYTE) else $error("null read not zero"); // RULE7
    chk_ptr_store: assert property (@(posedge mclk) disable iff (rst)
        doWr && hitPtrOne |=> ptrOne_reg == $past(req.wdata)) else $error("pointer one lost write"); // RULE8
    chk_direct_bank: assert property (@(posedge mclk) disable iff (rst)
        req.addr != OFF_IND_ONE |-> !target.bank) else $error("direct access left bank 0"); // RULE9
    chk_ind_bank: assert property (@(posedge mclk) disable iff (rst)
        req.addr == OFF_IND_ONE |-> target.bank == bankSel_reg
        && target.addr == ptrOne_reg[RAM_ADDR_W-1:0]) else $error("port one bank wrong"); // RULE6
    chk_nv_gate: assert property (@(posedge mclk) disable iff (rst)
        nvCtrlWrite |-> $past(bankSel_reg) && $past(req.addr) == OFF_IND_ONE) else $error("nv written outside bank 1"); // RULE16
    chk_bank_write: assert property (@(posedge mclk) disable iff (rst)
        doWr && hitBankSel |=> bankSelOut[0] == $past(req.wdata[0])) else $error("bank select not stored"); // RULE1
endmodule : bdm_data_memory
`default_nettype wire

// [verification/bdm_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module bdm_core_model
    import bdm_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic aluGo,
    input wire logic stepGo,
    input wire logic [DATA_W-1:0] aluValue,
    output logic aluResultValid,
    output logic [DATA_W-1:0] aluResult,
    output logic pcAdvance
);
    // alu results reach the accumulator only, never another register directly
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            aluResultValid <= 1'b0;
            aluResult <= 8'h00;
            pcAdvance <= 1'b0;
        end else begin
            aluResultValid <= aluGo;
            // result bus is not held once the strobe drops, so a stale sample shows up wrong
            aluResult <= aluGo ? aluValue : ~aluResult;
            pcAdvance <= stepGo;
        end
    end
endmodule : bdm_core_model
`default_nettype wire

// [verification/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import bdm_pkg::*;
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } bdm_row_t;
    localparam int ROWS = 22;
    localparam bdm_row_t TABLE [ROWS] = '{
        '{0, 1, 8'h03, 8'h50, 8'h00}, '{0, 1, 8'h04, 8'h01, 8'h00}, '{0, 1, 8'h02, 8'haa, 8'h00},
        '{0, 1, 8'h04, 8'h00, 8'h00}, '{0, 1, 8'h50, 8'h11, 8'h00}, '{0, 1, 8'h7f, 8'h5a, 8'h00},
        '{1, 0, 8'h50, 8'h00, 8'h11}, '{1, 0, 8'h02, 8'h00, 8'h11}, '{0, 1, 8'h04, 8'hff, 8'h00},
        '{1, 0, 8'h04, 8'h00, 8'h01}, '{1, 0, 8'h02, 8'h00, 8'haa}, '{1, 0, 8'h50, 8'h00, 8'h11},
        '{0, 1, 8'h01, 8'h50, 8'h00}, '{1, 0, 8'h00, 8'h00, 8'h11}, '{1, 0, 8'h01, 8'h00, 8'h50},
        '{0, 1, 8'h01, 8'h02, 8'h00}, '{0, 1, 8'h00, 8'h33, 8'h00}, '{1, 0, 8'h00, 8'h00, 8'h00},
        '{1, 0, 8'h01, 8'h00, 8'h02},
        '{1, 0, 8'h10, 8'h00, 8'h00}, '{1, 0, 8'h7f, 8'h00, 8'h5a}, '{0, 1, 8'h04, 8'h00, 8'h00}};
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic wdtSleepReset = 1'b0;
    bdm_req_t req = '0;
    logic aluGo = 1'b0;
    logic stepGo = 1'b0;
    logic [7:0] aluValue = 8'h00;
    logic pcLoad = 1'b0;
    logic [PC_W-1:0] pcLoadValue = '0;
    logic aluResultValid, pcAdvance, dummyCycle, nvCtrlWrite;
    logic [7:0] aluResult, readData, accumOut, bankSelOut;
    logic [PC_W-1:0] pcOut;
    logic [3:0] nvCtrlData;
    int err_count = 0;
    int samples_checked = 0;
    bdm_core_model core_u (.mclk(mclk), .rst(rst), .aluGo(aluGo), .stepGo(stepGo), .aluValue(aluValue),
        .aluResultValid(aluResultValid), .aluResult(aluResult), .pcAdvance(pcAdvance));
    bdm_data_memory dut_u (.mclk(mclk), .rst(rst), .wdtSleepReset(wdtSleepReset), .req(req),
        .aluResultValid(aluResultValid), .aluResult(aluResult), .pcAdvance(pcAdvance),
        .pcLoadValue(pcLoadValue), .pcLoad(pcLoad), .readData(readData), .accumOut(accumOut),
        .pcOut(pcOut), .dummyCycle(dummyCycle), .nvCtrlWrite(nvCtrlWrite), .nvCtrlData(nvCtrlData),
        .bankSelOut(bankSelOut));
    initial begin
        forever #4 mclk = ~mclk;
    end
    task end_of_test;
        if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    task chk(input logic [10:0] got, input logic [10:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // request is taken at the second edge; idle drops there so the next call never collides
    task access(input logic r, input logic w, input logic a, input logic [7:0] ad, input logic [7:0] wd);
        @(posedge mclk);
        req <= '{rd: r, wr: w, acc: a, addr: ad, wdata: wd};
        @(posedge mclk);
        req <= '0;
        #1;
    endtask : access
    task pulse_reset(input logic keep);
        access(0, 1, 0, 8'h04, 8'h01);
        wdtSleepReset <= keep;
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        wdtSleepReset <= 1'b0;
        @(posedge mclk);
        #1;
    endtask : pulse_reset
    initial begin
        repeat (5000) @(posedge mclk);
        err_count++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        #1 chk(11'(bankSelOut), 11'h000);
        chk(pcOut, 11'h000);
        for (int i = 0; i < ROWS; i++) begin
            access(TABLE[i].rd, TABLE[i].wr, 0, TABLE[i].addr, TABLE[i].wdata);
            if (TABLE[i].rd) chk(11'(readData), 11'(TABLE[i].exp));
        end
        access(0, 1, 1, 8'h05, 8'h3c);
        chk(11'(accumOut), 11'h03c);
        @(posedge mclk);
        aluValue <= 8'h77;
        aluGo <= 1'b1;
        @(posedge mclk);
        aluGo <= 1'b0;
        @(posedge mclk);
        #1 chk(11'(accumOut), 11'h077);
        access(0, 1, 0, 8'h03, 8'h40);
        access(0, 1, 0, 8'h04, 8'h01);
        access(0, 1, 0, 8'h02, 8'h0f);
        chk(11'(nvCtrlWrite), 11'h001);
        chk(11'(nvCtrlData), 11'h00f);
        access(1, 0, 0, 8'h02, 8'h00);
        chk(11'(readData), 11'h00f);
        access(0, 1, 0, 8'h04, 8'h00);
        access(1, 0, 0, 8'h02, 8'h00);
        chk(11'(readData), 11'h000);
        @(posedge mclk);
        pcLoadValue <= 11'h1fe;
        pcLoad <= 1'b1;
        @(posedge mclk);
        pcLoad <= 1'b0;
        stepGo <= 1'b1;
        @(posedge mclk);
        stepGo <= 1'b0;
        @(posedge mclk);
        #1 chk(pcOut, 11'h1ff);
        // a write lands exactly on the dummy cycle and must be lost
        @(posedge mclk);
        req <= '{rd: 1'b0, wr: 1'b1, acc: 1'b0, addr: 8'h06, wdata: 8'h12};
        @(posedge mclk);
        req <= '{rd: 1'b0, wr: 1'b1, acc: 1'b0, addr: 8'h7f, wdata: 8'h77};
        #1 chk(pcOut, 11'h112);
        chk(11'(dummyCycle), 11'h001);
        @(posedge mclk);
        req <= '0;
        #1 chk(11'(dummyCycle), 11'h000);
        access(1, 0, 0, 8'h7f, 8'h00);
        chk(11'(readData), 11'h05a);
        pulse_reset(1'b1);
        chk(11'(bankSelOut), 11'h001);
        pulse_reset(1'b0);
        chk(11'(bankSelOut), 11'h000);
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
